// ### logic/iwdt_decoder.sv
// Instruction word decoder with cycle timing and a Wishbone register port.
// Assumes fetch presents one 24-bit word per accept and the datapath reports
// condition results and flag updates in the same cycle as the related word.
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Accept 24-bit words; three opcodes use two
// - Top eight bits are the opcode
// - Second word must have zero top byte
// - A lone second word decodes as no-op
// - Taken condition or jump adds one no-op
// - Branches, tables, returns take two or three
// - Taken skip costs two, three over double-word
// - Double-word instructions and moves take two cycles
// - File operations decode address and destination choice
// - File address spans zero to 0x1FFF
// - Three register operands with address modes decoded
// - Bit number from literal or base register
// - Multiply class decodes accumulator, pair, prefetches
// - Write-back is W13 or post-incremented indirect
// - Unsigned ten-bit literal limited in byte mode
// - Program address literal always even
// - Signed literals sign-extended two's complement
// - Integer and per-accumulator status flags kept
// - Accumulator ops decode operand and shift source
// - Byte, double, word size and shadow select
// - Literal arithmetic destination only when separate
module iwdt_decoder (
  input wire logic clk,
  input wire logic rst,
  input wire logic instrValid,
  input wire logic [23:0] instrWord,
  input wire logic condTrue,
  input wire logic flagLoad,
  input wire logic [8:0] flagIn,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic instrReady,
  output logic decValid,
  output logic execNop,
  output logic [7:0] opcodeOut,
  output logic [4:0] instrClass,
  output logic [1:0] sizeSel,
  output logic shadowSel,
  output logic [12:0] fileAddr,
  output logic fileDestIsFile,
  output logic [3:0] baseOperandReg,
  output logic [3:0] sourceOperandReg,
  output logic [1:0] srcMode,
  output logic [3:0] destOperandReg,
  output logic [1:0] destMode,
  output logic destSeparate,
  output logic [3:0] bitSelectField,
  output logic bitFromReg,
  output logic accSel,
  output logic [2:0] mulPair,
  output logic [3:0] xPrefetch,
  output logic [1:0] xPrefetchDest,
  output logic [3:0] yPrefetch,
  output logic [1:0] yPrefetchDest,
  output logic accWritebackTarget,
  output logic shiftFromLiteral,
  output logic [3:0] shiftCountReg,
  output logic [5:0] shiftLiteral,
  output logic [9:0] unsignedTenBitLiteral,
  output logic [15:0] signedTenBitLiteral,
  output logic [15:0] signedSixteenBitLiteral,
  output logic [22:0] programAddressLiteral,
  output logic [8:0] statusFlags
);

  // ==========================================================================
  // State
  typedef struct packed {
    iwdt_pkg::iwdt_phase_e phase;
    logic [1:0] nopCnt;
    logic instrReady;
    logic decValid;
    logic execNop;
    logic [15:0] word1;
    logic [7:0] opcode;
    iwdt_pkg::iwdt_class_e cls;
    logic [1:0] sizeSel;
    logic shadowSel;
    logic [12:0] fileAddr;
    logic fileDestIsFile;
    logic [3:0] baseReg;
    logic [3:0] srcReg;
    logic [1:0] srcMode;
    logic [3:0] destReg;
    logic [1:0] destMode;
    logic destSeparate;
    logic [3:0] bitSel;
    logic bitFromReg;
    logic accSel;
    logic [2:0] mulPair;
    logic [3:0] xPre;
    logic [1:0] xDest;
    logic [3:0] yPre;
    logic [1:0] yDest;
    logic acc_writeback_target;
    logic shiftFromLit;
    logic [3:0] shiftReg;
    logic [5:0] shiftLit;
    logic [9:0] litU10;
    logic [15:0] litS10;
    logic [15:0] litS16;
    logic [22:0] progAddr;
    logic [8:0] flags;
    logic [3:0] errs;
    logic enable;
    logic [1:0] lastCycles;
    logic ack;
    logic [31:0] rdata;
  } iwdt_state_s;

  iwdt_state_s state_q;
  iwdt_state_s state_d;

  // Write mask from byte lanes
  function automatic logic [31:0] laneMask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : laneMask

  logic accept;
  logic [7:0] opIn;
  iwdt_pkg::iwdt_class_e clsIn;
  assign accept = state_q.instrReady & instrValid;
  assign opIn = instrWord[iwdt_pkg::POS_OPC +: iwdt_pkg::WID_OPC];
  assign clsIn = iwdt_pkg::classOf(opIn);

  // ==========================================================================
  // Next state: decode, timing, register port
  always_comb begin
    logic [3:0] errSet;
    logic [31:0] mask;
    logic [22:0] addr;
    logic wrHit;
    errSet = 4'h0;
    mask = laneMask(wb_sel_i);
    addr = 23'h00_0000;
    wrHit = 1'b0;
    state_d = state_q;
    state_d.decValid = 1'b0;
    // Pending no-op slots drain one per cycle
    state_d.execNop = (state_q.nopCnt != 2'h0);
    if (state_q.nopCnt != 2'h0) begin
      state_d.nopCnt = state_q.nopCnt - 2'h1;
    end
    case (state_q.phase)
      iwdt_pkg::PH_IDLE: begin
        if (accept) begin
          state_d.opcode = opIn;
          state_d.cls = clsIn;
          state_d.sizeSel = opIn[iwdt_pkg::POS_SIZE +: 2];
          state_d.shadowSel = opIn[iwdt_pkg::POS_SHADOW];
          // Every view is extracted; the class says which ones matter
          state_d.fileAddr = instrWord[iwdt_pkg::POS_FILE +: iwdt_pkg::WID_FILE];
          state_d.fileDestIsFile = instrWord[iwdt_pkg::POS_FDEST];
          state_d.baseReg = instrWord[iwdt_pkg::POS_WB +: 4];
          state_d.srcReg = instrWord[iwdt_pkg::POS_WS +: 4];
          state_d.srcMode = instrWord[iwdt_pkg::POS_WSM +: 2];
          state_d.destReg = instrWord[iwdt_pkg::POS_WD3 +: 4];
          state_d.destMode = instrWord[iwdt_pkg::POS_WDM3 +: 2];
          state_d.destSeparate = 1'b1;
          state_d.bitSel = instrWord[iwdt_pkg::POS_WB +: 4];
          state_d.bitFromReg = opIn[iwdt_pkg::POS_OPT];
          state_d.accSel = opIn[iwdt_pkg::POS_OPT];
          state_d.mulPair = instrWord[iwdt_pkg::POS_PAIR +: 3];
          state_d.xPre = instrWord[iwdt_pkg::POS_WX +: 4];
          state_d.xDest = instrWord[iwdt_pkg::POS_WXD +: 2];
          state_d.yPre = instrWord[iwdt_pkg::POS_WY +: 4];
          state_d.yDest = instrWord[iwdt_pkg::POS_WYD +: 2];
          state_d.acc_writeback_target = instrWord[iwdt_pkg::POS_AWB];
          state_d.shiftFromLit = instrWord[iwdt_pkg::POS_SHSRC];
          state_d.shiftReg = instrWord[iwdt_pkg::POS_SHIFT +: 4];
          state_d.shiftLit = instrWord[iwdt_pkg::POS_SHIFT +: 6];
          state_d.litU10 = instrWord[iwdt_pkg::POS_UNSIGNED_TEN_BIT_LITERAL +: 10];
          // Sign extension from the literal's top bit
          state_d.litS10 = {{6{instrWord[iwdt_pkg::POS_UNSIGNED_TEN_BIT_LITERAL + 9]}},
                            instrWord[iwdt_pkg::POS_UNSIGNED_TEN_BIT_LITERAL +: 10]};
          state_d.litS16 = instrWord[15:0];
          state_d.lastCycles = iwdt_pkg::CYC_ONE + iwdt_pkg::nopsFor(clsIn, condTrue);
          // Class-specific destination and checks
          case (clsIn)
            iwdt_pkg::CL_LITU, iwdt_pkg::CL_LITS: begin
              state_d.destReg = instrWord[iwdt_pkg::POS_WS +: 4];
              if (clsIn == iwdt_pkg::CL_LITU && opIn[1:0] == iwdt_pkg::SIZE_BYTE &&
                  instrWord[iwdt_pkg::POS_UNSIGNED_TEN_BIT_LITERAL +: 10] > iwdt_pkg::BYTE_LIT_MAX) begin
                errSet[iwdt_pkg::ERR_LIT_RANGE] = 1'b1;
              end
            end
            iwdt_pkg::CL_LIT16: begin
              state_d.destReg = opIn[3:0];
              state_d.sizeSel = iwdt_pkg::SIZE_WORD;
            end
            iwdt_pkg::CL_LITAR: begin
              // Without a separate destination the base register is written
              state_d.destSeparate = opIn[iwdt_pkg::POS_OPT];
              state_d.destReg = opIn[iwdt_pkg::POS_OPT] ?
                                instrWord[iwdt_pkg::POS_WDL +: 4] :
                                instrWord[iwdt_pkg::POS_WB +: 4];
              state_d.destMode = opIn[iwdt_pkg::POS_OPT] ?
                                 instrWord[iwdt_pkg::POS_WDML +: 2] : 2'h0;
            end
            iwdt_pkg::CL_ILLEGAL: begin
              errSet[iwdt_pkg::ERR_ILLEGAL] = 1'b1;
            end
            default: begin
            end
          endcase
          case (clsIn)
            iwdt_pkg::CL_DWORD: begin
              // Hold the first half until its partner arrives
              state_d.word1 = instrWord[15:0];
              state_d.phase = iwdt_pkg::PH_WAIT2;
            end
            iwdt_pkg::CL_SKIP: begin
              state_d.decValid = 1'b1;
              state_d.lastCycles = iwdt_pkg::CYC_ONE;
              if (condTrue) begin
                state_d.phase = iwdt_pkg::PH_SKIP;
              end
            end
            default: begin
              // Lone zero-opcode words land here as plain no-ops
              state_d.decValid = 1'b1;
              state_d.nopCnt = iwdt_pkg::nopsFor(clsIn, condTrue);
            end
          endcase
        end
      end
      iwdt_pkg::PH_WAIT2: begin
        if (accept) begin
          if (opIn != iwdt_pkg::OP_NOP) begin
            errSet[iwdt_pkg::ERR_SECOND_WORD] = 1'b1;
          end
          addr = {instrWord[iwdt_pkg::POS_ADDR_HI +: 7], state_q.word1};
          if (addr[0]) begin
            errSet[iwdt_pkg::ERR_ADDR_ODD] = 1'b1;
          end
          // Odd target would break fetch alignment, so bit 0 is forced low
          state_d.progAddr = {addr[22:1], 1'b0};
          state_d.decValid = 1'b1;
          state_d.lastCycles = iwdt_pkg::CYC_TWO;
          state_d.phase = iwdt_pkg::PH_IDLE;
        end
      end
      iwdt_pkg::PH_SKIP: begin
        if (accept) begin
          // Skipped word shows as a no-op slot
          state_d.execNop = 1'b1;
          if (clsIn == iwdt_pkg::CL_DWORD) begin
            state_d.lastCycles = iwdt_pkg::CYC_THREE;
            state_d.phase = iwdt_pkg::PH_SKIP2;
          end else begin
            state_d.lastCycles = iwdt_pkg::CYC_TWO;
            state_d.phase = iwdt_pkg::PH_IDLE;
          end
        end
      end
      iwdt_pkg::PH_SKIP2: begin
        if (accept) begin
          state_d.execNop = 1'b1;
          state_d.phase = iwdt_pkg::PH_IDLE;
        end
      end
      default: begin
        state_d.phase = iwdt_pkg::PH_IDLE;
      end
    endcase

    // Bus: ack one cycle after request, write at the edge that sees ack
    state_d.ack = wb_cyc_i & wb_stb_i & ~state_q.ack;
    wrHit = wb_cyc_i & wb_stb_i & wb_we_i & state_q.ack;
    state_d.errs = state_q.errs;
    if (wrHit && wb_adr_i == iwdt_pkg::ADR_STATUS) begin
      state_d.errs = state_q.errs & ~(wb_dat_i[3:0] & mask[3:0]);
    end
    // Hardware set wins over a same-cycle clear
    state_d.errs = state_d.errs | errSet;
    if (wrHit && wb_adr_i == iwdt_pkg::ADR_CTRL && wb_sel_i[0]) begin
      state_d.enable = wb_dat_i[0];
    end
    if (wrHit && wb_adr_i == iwdt_pkg::ADR_FLAGS) begin
      state_d.flags = (state_q.flags & ~mask[8:0]) | (wb_dat_i[8:0] & mask[8:0]);
    end
    // Datapath update takes priority over software
    if (flagLoad) begin
      state_d.flags = flagIn;
    end
    state_d.rdata = 32'h0000_0000;
    case (wb_adr_i)
      iwdt_pkg::ADR_CTRL: state_d.rdata[0] = state_q.enable;
      iwdt_pkg::ADR_STATUS: state_d.rdata[3:0] = state_q.errs;
      iwdt_pkg::ADR_FLAGS: state_d.rdata[8:0] = state_q.flags;
      iwdt_pkg::ADR_LASTOP: state_d.rdata[12:0] = {state_q.cls, state_q.opcode};
      iwdt_pkg::ADR_CYCLES: state_d.rdata[1:0] = state_q.lastCycles;
      default: state_d.rdata = 32'h0000_0000;
    endcase
    // Fetch stalls while no-op slots drain or software halts decode
    state_d.instrReady = state_d.enable & (state_d.nopCnt == 2'h0);
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= '0;
      state_q.phase <= iwdt_pkg::PH_IDLE;
      state_q.cls <= iwdt_pkg::CL_NOP;
      state_q.enable <= iwdt_pkg::RST_ENABLE;
      state_q.flags <= iwdt_pkg::RST_FLAGS;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Outputs straight from the state register
  assign wb_dat_o = state_q.rdata;
  assign wb_ack_o = state_q.ack;
  assign instrReady = state_q.instrReady;
  assign decValid = state_q.decValid;
  assign execNop = state_q.execNop;
  assign opcodeOut = state_q.opcode;
  assign instrClass = state_q.cls;
  assign sizeSel = state_q.sizeSel;
  assign shadowSel = state_q.shadowSel;
  assign fileAddr = state_q.fileAddr;
  assign fileDestIsFile = state_q.fileDestIsFile;
  assign baseOperandReg = state_q.baseReg;
  assign sourceOperandReg = state_q.srcReg;
  assign srcMode = state_q.srcMode;
  assign destOperandReg = state_q.destReg;
  assign destMode = state_q.destMode;
  assign destSeparate = state_q.destSeparate;
  assign bitSelectField = state_q.bitSel;
  assign bitFromReg = state_q.bitFromReg;
  assign accSel = state_q.accSel;
  assign mulPair = state_q.mulPair;
  assign xPrefetch = state_q.xPre;
  assign xPrefetchDest = state_q.xDest;
  assign yPrefetch = state_q.yPre;
  assign yPrefetchDest = state_q.yDest;
  assign accWritebackTarget = state_q.acc_writeback_target;
  assign shiftFromLiteral = state_q.shiftFromLit;
  assign shiftCountReg = state_q.shiftReg;
  assign shiftLiteral = state_q.shiftLit;
  assign unsignedTenBitLiteral = state_q.litU10;
  assign signedTenBitLiteral = state_q.litS10;
  assign signedSixteenBitLiteral = state_q.litS16;
  assign programAddressLiteral = state_q.progAddr;
  assign statusFlags = state_q.flags;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic idleAcc;
  assign idleAcc = accept && state_q.phase == iwdt_pkg::PH_IDLE;

  a_branch_one_nop: assert property (
    idleAcc && clsIn == iwdt_pkg::CL_BRANCH |=> decValid && !instrReady ##1 execNop)
    else $error("branch did not add one no-op slot");
  a_return_two_nops: assert property (
    idleAcc && clsIn == iwdt_pkg::CL_RETURN |=> decValid && !instrReady
    ##1 execNop && !instrReady ##1 execNop && instrReady)
    else $error("return did not take three cycles");
  a_skip_dword_three: assert property (
    state_q.phase == iwdt_pkg::PH_SKIP && accept && clsIn == iwdt_pkg::CL_DWORD
    |=> execNop && state_q.lastCycles == 2'h3)
    else $error("skip over double word not three cycles");
  a_dword_second_msb: assert property (
    state_q.phase == iwdt_pkg::PH_WAIT2 && accept && opIn != 8'h00
    |=> state_q.errs[iwdt_pkg::ERR_SECOND_WORD] && decValid)
    else $error("bad second word not flagged");
  a_dword_two_cycles: assert property (
    idleAcc && clsIn == iwdt_pkg::CL_DWORD ##1 accept |=> decValid && state_q.lastCycles == 2'h2)
    else $error("double word did not report two cycles");
  a_prog_addr_even: assert property (
    decValid && state_q.cls == iwdt_pkg::CL_DWORD |-> programAddressLiteral[0] == 1'b0)
    else $error("program address literal odd");
  a_file_addr_take: assert property (
    idleAcc && clsIn == iwdt_pkg::CL_FILE |=> fileAddr == $past(instrWord[12:0]))
    else $error("file address not decoded");
  a_unsigned_ten_bit_literal_byte: assert property (
    idleAcc && clsIn == iwdt_pkg::CL_LITU && opIn[1:0] == 2'h1 && instrWord[13:4] > 10'h0ff
    |=> state_q.errs[iwdt_pkg::ERR_LIT_RANGE])
    else $error("byte literal range not flagged");
  a_signed_ten_bit_literal_sign: assert property (
    idleAcc |=> signedTenBitLiteral[15:9] == {7{$past(instrWord[13])}})
    else $error("signed literal not sign-extended");
  a_flags_load: assert property (
    flagLoad |=> statusFlags == $past(flagIn))
    else $error("status flags not loaded");
  a_lit_dest_base: assert property (
    idleAcc && clsIn == iwdt_pkg::CL_LITAR && !opIn[3] |=> destOperandReg == baseOperandReg)
    else $error("literal op destination not base");

endmodule : iwdt_decoder

`default_nettype wire

// ### logic/iwdt_pkg.sv
// Constants, opcode map and decode helpers for the instruction word decoder.
// Assumes a 24-bit program word and a 32-bit classic Wishbone register port.
package iwdt_pkg;

  // ==========================================================================
  // Word format
  localparam int WORD_W = 24;
  localparam int POS_OPC = 16;
  localparam int WID_OPC = 8;

  // ==========================================================================
  // Opcode map; class is picked by the upper nibble, by the whole opcode when that nibble is zero
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_BRANCH = 8'h01;
  localparam logic [7:0] OP_BRANCH_COMP = 8'h02;
  localparam logic [7:0] OP_INDIRECT = 8'h03;
  localparam logic [7:0] OP_TBL_RD = 8'h04;
  localparam logic [7:0] OP_TBL_WR = 8'h05;
  localparam logic [7:0] OP_RETURN = 8'h06;
  localparam logic [7:0] OP_IRET = 8'h07;
  localparam logic [7:0] OP_COND_BRANCH = 8'h08;
  localparam logic [7:0] OP_SKIP = 8'h09;
  localparam logic [7:0] OP_DMOVE = 8'h0a;
  localparam logic [7:0] OP_DW_GOTO = 8'h0c;
  localparam logic [7:0] OP_DW_CALL = 8'h0d;
  localparam logic [7:0] OP_DW_LOOP = 8'h0e;

  // ==========================================================================
  // Operand field positions and widths
  localparam int POS_SIZE = 0;
  localparam int POS_SHADOW = 2;
  localparam int POS_OPT = 3;
  localparam int POS_FILE = 0;
  localparam int WID_FILE = 13;
  localparam int POS_FDEST = 13;
  localparam int POS_WS = 0;
  localparam int POS_WSM = 4;
  localparam int POS_WD3 = 6;
  localparam int POS_WDM3 = 10;
  localparam int POS_WB = 12;
  localparam int POS_WDL = 5;
  localparam int POS_WDML = 9;
  localparam int POS_UNSIGNED_TEN_BIT_LITERAL = 4;
  localparam int POS_AWB = 15;
  localparam int POS_PAIR = 12;
  localparam int POS_WX = 8;
  localparam int POS_WXD = 6;
  localparam int POS_WY = 2;
  localparam int POS_WYD = 0;
  localparam int POS_SHSRC = 6;
  localparam int POS_SHIFT = 7;
  localparam int POS_ADDR_HI = 0;
  localparam logic [9:0] BYTE_LIT_MAX = 10'h0ff;

  // Operand size codes in opcode bits 1:0; word is the default
  localparam logic [1:0] SIZE_WORD = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_DWORD = 2'h2;

  // ==========================================================================
  // Timing counts in instruction cycles
  localparam logic [1:0] NOPS_ONE = 2'h1;
  localparam logic [1:0] NOPS_TWO = 2'h2;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  // ==========================================================================
  // Register map, reset values and bit positions
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_FLAGS = 8'h08;
  localparam logic [7:0] ADR_LASTOP = 8'h0c;
  localparam logic [7:0] ADR_CYCLES = 8'h10;
  localparam logic RST_ENABLE = 1'b1;
  localparam logic [8:0] RST_FLAGS = 9'h000;
  localparam int ERR_SECOND_WORD = 0;
  localparam int ERR_ADDR_ODD = 1;
  localparam int ERR_LIT_RANGE = 2;
  localparam int ERR_ILLEGAL = 3;
  // Flag order: carry, digit carry, negative, overflow, zero, then accumulators
  localparam int FLAG_DIGIT_CARRY = 1;
  localparam int FLAG_OVERFLOW = 3;
  localparam int FLAG_ACC_A_OVERFLOW = 5;
  localparam int FLAG_ACC_SATURATE_B = 8;

  typedef enum logic [4:0] {
    CL_NOP, CL_BRANCH, CL_INDIRECT, CL_TABLE, CL_RETURN, CL_IRET, CL_CONDBR,
    CL_SKIP, CL_DMOVE, CL_DWORD, CL_FILE, CL_W3, CL_BIT, CL_LITU, CL_LITS,
    CL_LIT16, CL_LITAR, CL_MAC, CL_ACC, CL_ILLEGAL
  } iwdt_class_e;

  typedef enum logic [1:0] {PH_IDLE, PH_WAIT2, PH_SKIP, PH_SKIP2} iwdt_phase_e;

  // Opcode to instruction class
  function automatic iwdt_class_e classOf(input logic [7:0] op);
    iwdt_class_e c;
    c = CL_ILLEGAL;
    case (op[7:4])
      4'h0: begin
        case (op)
          OP_NOP: c = CL_NOP;
          OP_BRANCH, OP_BRANCH_COMP: c = CL_BRANCH;
          OP_INDIRECT: c = CL_INDIRECT;
          OP_TBL_RD, OP_TBL_WR: c = CL_TABLE;
          OP_RETURN: c = CL_RETURN;
          OP_IRET: c = CL_IRET;
          OP_COND_BRANCH: c = CL_CONDBR;
          OP_SKIP: c = CL_SKIP;
          OP_DMOVE: c = CL_DMOVE;
          OP_DW_GOTO, OP_DW_CALL, OP_DW_LOOP: c = CL_DWORD;
          default: c = CL_ILLEGAL;
        endcase
      end
      4'h1: c = CL_FILE;
      4'h2: c = CL_W3;
      4'h3: c = CL_BIT;
      4'h4: c = CL_LITU;
      4'h5: c = CL_LITS;
      4'h6: c = CL_LIT16;
      4'h7: c = CL_LITAR;
      4'h8: c = CL_MAC;
      4'h9: c = CL_ACC;
      default: c = CL_ILLEGAL;
    endcase
    return c;
  endfunction : classOf

  // Extra no-operation cycles after the first one
  function automatic logic [1:0] nopsFor(input iwdt_class_e c, input logic condTrue);
    logic [1:0] n;
    n = 2'h0;
    case (c)
      CL_BRANCH, CL_INDIRECT, CL_TABLE, CL_DMOVE: n = NOPS_ONE;
      CL_RETURN, CL_IRET: n = NOPS_TWO;
      CL_CONDBR: n = condTrue ? NOPS_ONE : 2'h0;
      default: n = 2'h0;
    endcase
    return n;
  endfunction : nopsFor

endpackage : iwdt_pkg

// ### bench/iwdt_fetch.sv
// Fetch model: offers queued program words to the decoder one at a time.
// Assumes a word is taken at a rising edge where ready and valid are high.
`timescale 1ns/1ps
`default_nettype none
module iwdt_fetch (
  input wire logic clk,
  input wire logic instrReady,
  output logic instrValid,
  output logic [23:0] instrWord
);
  logic [23:0] q[$];
  // ==========================================================================
  // Offer the queue head until taken; idle shows the inverse so no stale word
  initial begin
    instrValid = 1'b0;
    instrWord = 24'h00_0000;
  end
  always @(posedge clk) begin
    if (instrValid && instrReady) void'(q.pop_front());
    instrValid <= (q.size() != 0);
    instrWord <= (q.size() != 0) ? q[0] : ~instrWord; // Whole 24-bit words
  end
endmodule : iwdt_fetch
`default_nettype wire

// ### bench/testbench.sv
// Testbench for the instruction word decoder: timing, fields and registers.
// Assumes the fetch model beside it and classic Wishbone with one-cycle ack.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rst, condTrue, flagLoad, instrValid, instrReady, decValid, execNop;
  logic cyc, stb, we, wb_ack_o, fileDestIsFile;
  logic [8:0] flagIn;
  logic [7:0] adr;
  logic [31:0] wdat, wb_dat_o, rd;
  logic [23:0] instrWord;
  logic [4:0] instrClass;
  logic [12:0] fileAddr;
  logic [22:0] programAddressLiteral;
  logic accSel, accWritebackTarget, shadowSel;
  logic [1:0] sizeSel;
  logic [2:0] mulPair;
  logic [3:0] bitSelectField, destOperandReg;
  logic [8:0] statusFlags;
  logic [9:0] unsignedTenBitLiteral;
  logic [15:0] signedTenBitLiteral, signedSixteenBitLiteral;
  int failures = 0, checked = 0, nDec = 0, nNop = 0;
  iwdt_fetch fetch (.clk(clk), .instrReady(instrReady), .instrValid(instrValid),
    .instrWord(instrWord));
  iwdt_decoder dut (.clk(clk), .rst(rst), .instrValid(instrValid), .instrWord(instrWord),
    .condTrue(condTrue), .flagLoad(flagLoad), .flagIn(flagIn), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .instrReady(instrReady),
    .decValid(decValid), .execNop(execNop), .opcodeOut(), .instrClass(instrClass),
    .sizeSel(sizeSel), .shadowSel(shadowSel), .fileAddr(fileAddr),
    .fileDestIsFile(fileDestIsFile), .baseOperandReg(), .sourceOperandReg(), .srcMode(),
    .destOperandReg(destOperandReg), .destMode(), .destSeparate(),
    .bitSelectField(bitSelectField), .bitFromReg(), .accSel(accSel), .mulPair(mulPair),
    .xPrefetch(), .xPrefetchDest(), .yPrefetch(), .yPrefetchDest(),
    .accWritebackTarget(accWritebackTarget), .shiftFromLiteral(), .shiftCountReg(),
    .shiftLiteral(), .unsignedTenBitLiteral(unsignedTenBitLiteral),
    .signedTenBitLiteral(signedTenBitLiteral),
    .signedSixteenBitLiteral(signedSixteenBitLiteral),
    .programAddressLiteral(programAddressLiteral), .statusFlags(statusFlags));
  // ==========================================================================
  // Clock, pulse counters and watchdog
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (decValid === 1'b1) nDec++;
    if (execNop === 1'b1) nNop++;
  end
  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    results();
  end
  // ==========================================================================
  // Shared tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (exp !== got) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    // The wait ends at ack; only the watchdog ends a wait that never sees it
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o; // Taken at the ack edge only
    {cyc, stb, we} <= 3'b000;
    @(posedge clk);
  endtask : wbx
  task automatic run(input logic [23:0] w[$]);
    {nDec, nNop} = 64'h0000_0000_0000_0000;
    foreach (w[i]) fetch.q.push_back(w[i]);
    while (fetch.q.size() != 0 || instrReady !== 1'b1) begin
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask : run
  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    wbx(1'b0, 8'h00, 0); chk("ctrl", 32'h0000_0001, rd); // Enable resets to one
    @(posedge clk) {flagLoad, flagIn} <= {1'b1, 9'h1a5};
    @(posedge clk) flagLoad <= 1'b0;
    wbx(1'b0, 8'h08, 0); chk("flags", 32'h0000_01a5, rd);
    chk("flag pins", 32'h0000_01a5, statusFlags);
    wbx(1'b0, 8'h40, 0); chk("unmapped", 32'h0000_0000, rd);
    $display("test regs done");
  endtask : t_regs
  task automatic t_timing;
    run('{24'h01_0000, 24'h06_0000});
    chk("decodes", 2, nDec);
    chk("nops", 3, nNop);
    wbx(1'b0, 8'h10, 0); chk("cycles", 3, rd);
    run('{24'h0c_1234, 24'h00_0001}); // Even target address
    chk("dw decodes", 1, nDec);
    chk("dw addr", 32'h0001_1234, {9'h000, programAddressLiteral});
    wbx(1'b0, 8'h10, 0); chk("dw cycles", 2, rd);
    run('{24'h00_0055}); chk("lone", 0, instrClass);
    $display("test timing done");
  endtask : t_timing
  task automatic t_fields;
    run('{24'h88_d999});
    chk("awb", 1, accWritebackTarget);
    chk("acc", 1, accSel);
    chk("pair", 5, mulPair);
    run('{24'h35_a000});
    chk("bit", 32'h0000_000a, bitSelectField);
    chk("size", 1, sizeSel);
    chk("shadow", 1, shadowSel);
    run('{24'h6c_8001});
    chk("s16", 32'h0000_8001, signedSixteenBitLiteral);
    chk("lit16 dest", 32'h0000_000c, destOperandReg);
    run('{24'h70_5000});
    chk("base dest", 5, destOperandReg);
    run('{24'h52_2000});
    chk("s10", 32'h0000_fe00, signedTenBitLiteral);
    run('{24'h41_1ff0});
    chk("u10", 32'h0000_01ff, unsignedTenBitLiteral);
    wbx(1'b0, 8'h04, 0);
    chk("lit err", 32'h0000_0004, rd);
    run('{24'h0c_0003, 24'h01_0000});
    chk("even", 32'h0000_0002, {9'h000, programAddressLiteral});
    wbx(1'b0, 8'h04, 0);
    chk("dw err", 32'h0000_0007, rd);
    wbx(1'b1, 8'h04, 32'h0000_0007);
    wbx(1'b0, 8'h04, 0);
    chk("w1c", 0, rd);
    $display("test fields done");
  endtask : t_fields
  task automatic t_skip;
    condTrue <= 1'b1;
    run('{24'h09_0000, 24'h0d_0010, 24'h00_0000, 24'h10_3fff});
    chk("skip nops", 2, nNop);
    chk("file addr", 13'h1fff, fileAddr);
    chk("file dest", 1, fileDestIsFile);
    $display("test skip done");
  endtask : t_skip
  task automatic results;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  initial begin
    {rst, condTrue, flagLoad, flagIn, cyc, stb, we, adr, wdat} = {1'b1, 54'h0};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_regs();
    t_timing();
    t_fields();
    t_skip();
    results();
  end
endmodule : testbench
`default_nettype wire
